//--- verilog/rstr_readback.v
/*
 Rectifier status and telemetry readback: answers manufacturer read
 commands one byte at a time toward the bus slave engine, which owns
 addressing, acknowledge and packet error check generation.
 Assumes cmd_valid pulses once per read with the command code, and
 byte_req pulses once per data byte the engine wants.
*/
// Function
// - Alarm query returns interface, power-path, output bytes
// - Interface alarm bit layout, reset to zero
// - Share current over 10A sets bit zero
// - Early warning 5 degrees before overtemp shutdown
// - Fan query: six bytes, percent, fan1, fan2
// - Absent fan or unsupported returns zero
// - Input query: four bytes, voltage then power
// - Firmware query: six revision bytes, three controllers
// - Hours query returns accumulated on hours
// - Hour count never restarts from zero
// - Hours count in standby and main output
// - Hour counter spans 24 bits, about 1900 years
// - Multi-byte values sent low byte first
// - Block reads begin with data byte count
// - Status pair returns second status, then unit
`include "rstr_consts.vh"

module rstr_readback #(
  parameter [47:0] TICKS_PER_HOUR = `RSTR_CLK_HZ * 48'd3600,
  parameter HW = `RSTR_HOURS_WIDTH,
  parameter [7:0] FW_PRI_MAJ = 8'h01, // Arbitrary revision values
  parameter [7:0] FW_PRI_MIN = 8'h00,
  parameter [7:0] FW_SEC_MAJ = 8'h01,
  parameter [7:0] FW_SEC_MIN = 8'h00,
  parameter [7:0] FW_BUS_MAJ = 8'h01,
  parameter [7:0] FW_BUS_MIN = 8'h00
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Command side from bus engine
  input wire cmd_valid,
  input wire [7:0] cmd_code,
  input wire byte_req,
  input wire read_done,
  // Byte answer
  output reg [7:0] rd_byte_reg,
  output reg rd_valid_reg,
  output reg cmd_known_reg,
  // Raw fault inputs (asynchronous)
  input wire interlock_open,
  input wire fuse_fail,
  input wire [2:0] link_fault,
  input wire isolation_fault,
  input wire [6:0] power_path_other,
  input wire [7:0] output_other,
  input wire [7:0] unit_state_in,
  input wire [7:0] status_second_in,
  // Measurements (same clock domain)
  input wire [15:0] share_current_ma,
  input wire [7:0] temp_degc,
  input wire [7:0] overtemp_shutdown_flag_degc,
  input wire [15:0] fan_cmd_pct,
  input wire [15:0] fan1_rpm,
  input wire [15:0] fan2_rpm,
  input wire fan1_present,
  input wire fan2_present,
  input wire fan_supported,
  input wire [15:0] vin,
  input wire [15:0] pin,
  // Run timer
  input wire unit_powered,
  input wire hours_load,
  input wire [HW-1:0] hours_preset,
  // Visible flags
  output reg overtemp_early_warning_reg,
  output reg share_fault_reg
);
  localparam ST_IDLE = 3'b001;
  localparam ST_SEND = 3'b010;
  localparam ST_DONE = 3'b100;

  reg [2:0] state_reg;
  reg [7:0] cmd_reg;
  reg [2:0] idx_reg;
  reg [2:0] last_reg;
  reg [7:0] async_s1_reg;
  reg [7:0] async_s2_reg;
  reg [7:0] out_s1_reg;
  reg [7:0] out_s2_reg;
  reg [7:0] unit_s1_reg;
  reg [7:0] unit_s2_reg;
  reg [7:0] sec_s1_reg;
  reg [7:0] sec_s2_reg;
  reg [6:0] pp_s1_reg;
  reg [6:0] pp_s2_reg;
  reg [7:0] interface_alarm_flags;
  reg [7:0] power_path_alarm_flags;
  reg [7:0] output_alarm_flags;
  reg [7:0] unit_state_flags;
  reg [7:0] byte_next;
  reg [2:0] last_next;
  reg known_next;
  wire [HW-1:0] hours;
  wire [8:0] ot_warn_sum;

  // Margin is added to the reading so a low shutdown level cannot wrap below zero
  assign ot_warn_sum = {1'b0, temp_degc} + {1'b0, `RSTR_OT_MARGIN_DEGC};

  rstr_hour_timer #(
    .TICKS_PER_HOUR(TICKS_PER_HOUR),
    .W(HW)
  ) u_hours (
    .clk(clk),
    .rst(rst),
    .load(hours_load),
    .preset(hours_preset),
    .unit_on(unit_powered),
    .hours_reg(hours)
  );

  // Pins from fault sources are resynchronised before use
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      async_s1_reg <= `RSTR_ALARM_RESET;
      async_s2_reg <= `RSTR_ALARM_RESET;
      out_s1_reg <= `RSTR_ALARM_RESET;
      out_s2_reg <= `RSTR_ALARM_RESET;
      unit_s1_reg <= 8'h00;
      unit_s2_reg <= 8'h00;
      sec_s1_reg <= 8'h00;
      sec_s2_reg <= 8'h00;
      pp_s1_reg <= 7'h00;
      pp_s2_reg <= 7'h00;
    end else begin
      async_s1_reg <= {interlock_open, fuse_fail, link_fault, 2'b00, isolation_fault};
      async_s2_reg <= async_s1_reg;
      out_s1_reg <= output_other;
      out_s2_reg <= out_s1_reg;
      unit_s1_reg <= unit_state_in;
      unit_s2_reg <= unit_s1_reg;
      sec_s1_reg <= status_second_in;
      sec_s2_reg <= sec_s1_reg;
      pp_s1_reg <= power_path_other;
      pp_s2_reg <= pp_s1_reg;
    end
  end

  // Alarm byte assembly
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      interface_alarm_flags <= `RSTR_ALARM_RESET;
      power_path_alarm_flags <= `RSTR_ALARM_RESET;
      output_alarm_flags <= `RSTR_ALARM_RESET;
      unit_state_flags <= 8'h00;
      share_fault_reg <= 1'b0;
      overtemp_early_warning_reg <= 1'b0;
    end else begin
      interface_alarm_flags <= async_s2_reg & 8'hF9;
      share_fault_reg <= share_current_ma > `RSTR_SHARE_LIMIT_MA;
      power_path_alarm_flags <= {pp_s2_reg,
                                 share_current_ma > `RSTR_SHARE_LIMIT_MA};
      overtemp_early_warning_reg <= ot_warn_sum >= {1'b0, overtemp_shutdown_flag_degc};
      output_alarm_flags <= {out_s2_reg[7:5],
                             ot_warn_sum >= {1'b0, overtemp_shutdown_flag_degc},
                             out_s2_reg[3:0]};
      unit_state_flags <= unit_s2_reg;
    end
  end

  // Byte selection for the current command and index
  always @* begin
    byte_next = `RSTR_FILL;
    last_next = 3'd0;
    known_next = 1'b1;
    case (cmd_reg)
      `RSTR_CMD_STATUS_PAIR: begin
        last_next = 3'd1;
        byte_next = (idx_reg == 3'd0) ? sec_s2_reg : unit_state_flags;
      end
      `RSTR_CMD_ALARM: begin
        last_next = 3'd2;
        case (idx_reg)
          3'd0: byte_next = interface_alarm_flags;
          3'd1: byte_next = power_path_alarm_flags;
          default: byte_next = output_alarm_flags;
        endcase
      end
      `RSTR_CMD_FAN: begin
        last_next = 3'd6;
        case (idx_reg)
          3'd0: byte_next = `RSTR_CNT_FAN;
          3'd1: byte_next = fan_supported ? fan_cmd_pct[7:0] : `RSTR_FILL;
          3'd2: byte_next = fan_supported ? fan_cmd_pct[15:8] : `RSTR_FILL;
          3'd3: byte_next = (fan_supported & fan1_present) ? fan1_rpm[7:0] : `RSTR_FILL;
          3'd4: byte_next = (fan_supported & fan1_present) ? fan1_rpm[15:8] : `RSTR_FILL;
          3'd5: byte_next = (fan_supported & fan2_present) ? fan2_rpm[7:0] : `RSTR_FILL;
          default: byte_next = (fan_supported & fan2_present) ? fan2_rpm[15:8] : `RSTR_FILL;
        endcase
      end
      `RSTR_CMD_INPUT: begin
        last_next = 3'd4;
        case (idx_reg)
          3'd0: byte_next = `RSTR_CNT_INPUT;
          3'd1: byte_next = vin[7:0];
          3'd2: byte_next = vin[15:8];
          3'd3: byte_next = pin[7:0];
          default: byte_next = pin[15:8];
        endcase
      end
      `RSTR_CMD_FW_REV: begin
        last_next = 3'd6;
        case (idx_reg)
          3'd0: byte_next = `RSTR_CNT_FW;
          3'd1: byte_next = FW_PRI_MAJ;
          3'd2: byte_next = FW_PRI_MIN;
          3'd3: byte_next = FW_SEC_MAJ;
          3'd4: byte_next = FW_SEC_MIN;
          3'd5: byte_next = FW_BUS_MAJ;
          default: byte_next = FW_BUS_MIN;
        endcase
      end
      `RSTR_CMD_RUN_TIMER: begin
        last_next = 3'd3;
        case (idx_reg)
          3'd0: byte_next = `RSTR_CNT_TIMER;
          3'd1: byte_next = hours[7:0];
          3'd2: byte_next = hours[15:8];
          default: byte_next = hours[23:16];
        endcase
      end
      default: known_next = 1'b0;
    endcase
  end

  // Sequencer; the host closes each read itself with no-ack and stop
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cmd_reg <= 8'h00;
      idx_reg <= 3'd0;
      last_reg <= 3'd0;
      rd_byte_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
      cmd_known_reg <= 1'b0;
    end else begin
      rd_valid_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (cmd_valid) begin
            cmd_reg <= cmd_code;
            idx_reg <= 3'd0;
            state_reg <= ST_SEND;
          end
        end
        ST_SEND: begin
          cmd_known_reg <= known_next;
          last_reg <= last_next;
          if (read_done) begin
            state_reg <= ST_IDLE;
          end else if (byte_req) begin
            rd_byte_reg <= byte_next;
            rd_valid_reg <= 1'b1;
            if (idx_reg == last_next)
              state_reg <= ST_DONE;
            else
              idx_reg <= idx_reg + 3'd1;
          end
        end
        ST_DONE: begin
          // Extra byte requests past the end answer with fill
          if (read_done) begin
            state_reg <= ST_IDLE;
          end else if (byte_req) begin
            rd_byte_reg <= `RSTR_FILL;
            rd_valid_reg <= 1'b1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule

//--- verilog/rstr_consts.vh
/*
 Constants for the rectifier status and telemetry readback block:
 command codes, byte counts, alarm bit positions and timing counts.
 Assumes inclusion by bare name from the design files.
*/
`ifndef RSTR_CONSTS_VH
`define RSTR_CONSTS_VH

`define RSTR_CMD_STATUS_PAIR 8'hD1
`define RSTR_CMD_ALARM 8'hD2
`define RSTR_CMD_FAN 8'hD3
`define RSTR_CMD_INPUT 8'hD4
`define RSTR_CMD_FW_REV 8'hD5
`define RSTR_CMD_RUN_TIMER 8'hD6

`define RSTR_CNT_FAN 8'h06
`define RSTR_CNT_INPUT 8'h04
`define RSTR_CNT_FW 8'h06
`define RSTR_CNT_TIMER 8'h03

`define RSTR_IFA_INTERLOCK 7
`define RSTR_IFA_FUSE 6
`define RSTR_IFA_LINK_HI 5
`define RSTR_IFA_LINK_LO 3
`define RSTR_IFA_ISOLATION 0
`define RSTR_PPA_SHARE 0
`define RSTR_OUA_OT_WARN 4
`define RSTR_OUA_OT_SHDN 5
`define RSTR_ALARM_RESET 8'h00

`define RSTR_SHARE_LIMIT_MA 16'h2710
`define RSTR_OT_MARGIN_DEGC 8'h05

`define RSTR_CLK_HZ 100000000
`define RSTR_SECONDS_PER_HOUR 3600
`define RSTR_HOURS_WIDTH 24
`define RSTR_FILL 8'h00
`endif

//--- verilog/rstr_hour_timer.v
/*
 Operating-hour accumulator. Counts clock ticks while the unit is
 powered (standby or main output) and steps a saturating hour count.
 Assumes the preset value is loaded from non-volatile storage.
*/
`include "rstr_consts.vh"

module rstr_hour_timer #(
  parameter [47:0] TICKS_PER_HOUR = `RSTR_CLK_HZ * 48'd3600,
  parameter W = `RSTR_HOURS_WIDTH
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Control
  input wire load,
  input wire [W-1:0] preset,
  input wire unit_on,
  // Count
  output reg [W-1:0] hours_reg
);
  reg [47:0] tick_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_reg <= 48'h0000_0000_0000;
      hours_reg <= {W{1'b0}};
    end else if (load) begin
      hours_reg <= preset;
      tick_reg <= 48'h0000_0000_0000;
    end else if (unit_on) begin
      if (tick_reg == TICKS_PER_HOUR - 48'h0000_0000_0001) begin
        tick_reg <= 48'h0000_0000_0000;
        // Saturates rather than wrapping so the count never restarts
        if (hours_reg != {W{1'b1}})
          hours_reg <= hours_reg + {{(W-1){1'b0}}, 1'b1};
      end else begin
        tick_reg <= tick_reg + 48'h0000_0000_0001;
      end
    end
  end
endmodule

//--- verification/rstr_readback_properties.sv
/*
 Readback checker: answer timing, byte counts, fill bytes and flags.
 Assumes the readback ports; inputs stay steady while a read is open.
*/
module rstr_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host requests and inputs
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic byte_req,
  input wire logic read_done,
  input wire logic fan_supported,
  input wire logic [15:0] share_current_ma,
  input wire logic [7:0] temp_degc,
  input wire logic [7:0] overtemp_shutdown_flag_degc,
  // Answers and flags
  input wire logic [7:0] rd_byte_reg,
  input wire logic rd_valid_reg,
  input wire logic cmd_known_reg,
  input wire logic overtemp_early_warning_reg,
  input wire logic share_fault_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy;
  logic known;
  logic [7:0] code_r;
  logic [3:0] idx;
  logic [3:0] len;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Mirror of the open read; a command while busy is dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      code_r <= 8'h00;
      idx <= 4'h0;
    end else begin
      if (rd_valid_reg)
        idx <= idx + 4'h1;
      if (!busy && cmd_valid) begin
        busy <= 1'b1;
        code_r <= cmd_code;
        idx <= 4'h0;
      end else if (read_done)
        busy <= 1'b0;
    end
  end
  always_comb begin
    known = code_r >= 8'hD1 && code_r <= 8'hD6;
    case (code_r)
      8'hD1: len = 4'h2;
      8'hD2: len = 4'h3;
      8'hD4: len = 4'h5;
      8'hD6: len = 4'h4;
      default: len = known ? 4'h7 : 4'h0;
    endcase
  end
  sequence s_req;
    busy && byte_req && !cmd_valid;
  endsequence
  // Flags are judged only once two clean edges have passed
  sequence s_settled;
    !$past(rst) && !$past(rst, 2);
  endsequence
  valid_after_req_a: assert property (s_req |=> rd_valid_reg)
    else $error("no answer after a byte request");
  valid_cause_a: assert property (rd_valid_reg |-> $past(byte_req))
    else $error("answer without a request");
  known_flag_a: assert property (rd_valid_reg |-> cmd_known_reg == known)
    else $error("command support flag wrong");
  count_first_a: assert property (
    rd_valid_reg && idx == 4'h0 && code_r > 8'hD2 && known |-> rd_byte_reg == {4'h0, len - 4'h1})
    else $error("block count byte wrong");
  tail_zero_a: assert property (rd_valid_reg && idx >= len |-> rd_byte_reg == 8'h00)
    else $error("fill byte not zero");
  fan_unsup_a: assert property (
    rd_valid_reg && code_r == 8'hD3 && idx != 4'h0 && !fan_supported |-> rd_byte_reg == 8'h00)
    else $error("unsupported fan data not zero");
  share_flag_a: assert property (
    s_settled |-> share_fault_reg == ($past(share_current_ma) > 16'h2710))
    else $error("share fault flag wrong");
  warn_flag_a: assert property (s_settled |-> overtemp_early_warning_reg ==
    ({1'b0, $past(temp_degc)} + 9'h005 >= {1'b0, $past(overtemp_shutdown_flag_degc)}))
    else $error("early warning flag wrong");
endmodule
bind rstr_readback rstr_props rstr_props_i (.clk, .rst, .cmd_valid, .cmd_code, .byte_req,
  .read_done, .fan_supported, .share_current_ma, .temp_degc, .overtemp_shutdown_flag_degc, .rd_byte_reg,
  .rd_valid_reg, .cmd_known_reg, .overtemp_early_warning_reg, .share_fault_reg);

//--- verification/rstr_host_model.sv
/*
 Bus host model: sends a read command, asks for bytes, ends the read.
 Assumes the bench calls rd between reads; drives on falling edges.
*/
module rstr_host_model (
  // Clock
  input wire logic clk,
  // Requests
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic byte_req,
  output logic read_done,
  // Answers
  input wire logic [7:0] rd_byte_reg,
  input wire logic rd_valid_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] got;
  logic [7:0] vmask;
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    byte_req = 1'b0;
    read_done = 1'b0;
  end
  // A nonzero code2 is a second command sent while the first is open
  task automatic rd(input logic [7:0] code, input logic [7:0] code2, input int n, input int gap);
    got = '0;
    vmask = '0;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code = code;
    if (code2 != 8'h00) begin
      @(negedge clk);
      cmd_code = code2;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_code = ~cmd_code;
    for (int i = 0; i < n; i++) begin
      byte_req = 1'b1;
      @(negedge clk);
      got = {got[55:0], rd_byte_reg};
      vmask = {vmask[6:0], rd_valid_reg};
      if (gap > 0) begin
        byte_req = 1'b0;
        repeat (gap) @(negedge clk);
      end
    end
    byte_req = 1'b0;
    read_done = 1'b1;
    @(negedge clk);
    read_done = 1'b0;
    @(negedge clk);
  endtask
endmodule

//--- verification/rstr_readback_tb_top.sv
/*
 Bench for the readback block: every command read through the host model.
 Assumes the design, checker and host model files compile first.
*/
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module rstr_readback_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [7:0] code;
    logic [7:0] code2;
    int n;
    logic [2:0] fans;
    logic [63:0] exp;
  } rstr_row_t;
  // Fans field is {fan1_present, fan2_present, fan_supported}
  rstr_row_t rows [10] = '{
    '{8'hD1, 8'hD5, 2, 3'b111, 64'h0000_0000_0000_4281},
    '{8'hD2, 8'h00, 3, 3'b111, 64'h0000_0000_00A9_AB10},
    '{8'hD3, 8'h00, 8, 3'b111, 64'h0632_00B8_0B1C_0C00},
    '{8'hD3, 8'h00, 7, 3'b101, 64'h0006_3200_B80B_0000},
    '{8'hD3, 8'h00, 7, 3'b011, 64'h0006_3200_0000_1C0C},
    '{8'hD3, 8'h00, 7, 3'b110, 64'h0006_0000_0000_0000},
    '{8'hD4, 8'h00, 5, 3'b111, 64'h0000_0004_3412_CDAB},
    '{8'hD5, 8'h00, 7, 3'b111, 64'h0006_1112_2122_3132},
    '{8'hD6, 8'h00, 4, 3'b111, 64'h0000_0000_0302_0100},
    '{8'hD7, 8'h00, 2, 3'b111, 64'h0000_0000_0000_0000}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid, byte_req, read_done, rd_valid_reg, cmd_known_reg;
  logic overtemp_early_warning_reg, share_fault_reg;
  logic [7:0] cmd_code, rd_byte_reg;
  logic interlock_open = 1'b1, fuse_fail = 1'b0, isolation_fault = 1'b1;
  logic [2:0] link_fault = 3'h5;
  logic [6:0] power_path_other = 7'h55;
  logic [7:0] output_other = 8'h00, unit_state_in = 8'h81, status_second_in = 8'h42;
  logic [15:0] share_current_ma = 16'h2711, fan_cmd_pct = 16'h0032, fan1_rpm = 16'h0BB8;
  logic [15:0] fan2_rpm = 16'h0C1C, vin = 16'h1234, pin = 16'hABCD;
  logic [7:0] temp_degc = 8'h5A, overtemp_shutdown_flag_degc = 8'h5F;
  logic fan1_present = 1'b1, fan2_present = 1'b1, fan_supported = 1'b1;
  logic unit_powered = 1'b0, hours_load = 1'b0;
  logic [23:0] hours_preset = 24'h00_0102;
  int err_total = 0;
  int comparisons = 0;
  // A short hour keeps the run timer test brief
  // Distinct revision bytes so a swapped controller order shows up
  rstr_readback #(.TICKS_PER_HOUR(48'h0000_0000_000A), .FW_PRI_MAJ(8'h11), .FW_PRI_MIN(8'h12),
    .FW_SEC_MAJ(8'h21), .FW_SEC_MIN(8'h22), .FW_BUS_MAJ(8'h31), .FW_BUS_MIN(8'h32))
    rstr_readback_i (.clk, .rst, .cmd_valid, .cmd_code,
    .byte_req, .read_done, .rd_byte_reg, .rd_valid_reg, .cmd_known_reg, .interlock_open,
    .fuse_fail, .link_fault, .isolation_fault, .power_path_other, .output_other, .unit_state_in,
    .status_second_in, .share_current_ma, .temp_degc, .overtemp_shutdown_flag_degc, .fan_cmd_pct,
    .fan1_rpm, .fan2_rpm, .fan1_present, .fan2_present, .fan_supported, .vin, .pin,
    .unit_powered, .hours_load, .hours_preset, .overtemp_early_warning_reg, .share_fault_reg);
  rstr_host_model rstr_host_model_i (.clk, .cmd_valid, .cmd_code, .byte_req, .read_done,
    .rd_byte_reg, .rd_valid_reg);
  initial forever #5 clk = ~clk;
  task automatic final_report;
    $display("Comparisons %0d, errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    final_report;
  end
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    hours_load = 1'b1;
    @(negedge clk);
    hours_load = 1'b0;
    repeat (5) @(negedge clk);
    foreach (rows[i]) begin
      {fan1_present, fan2_present, fan_supported} = rows[i].fans;
      rstr_host_model_i.rd(rows[i].code, rows[i].code2, rows[i].n, rows[i].n % 2 * 2);
      `CHK("bytes", rows[i].exp, rstr_host_model_i.got)
      `CHK("valid", 8'((1 << rows[i].n) - 1), rstr_host_model_i.vmask)
      `CHK("known", rows[i].code >= 8'hD1 && rows[i].code <= 8'hD6, cmd_known_reg)
    end
    // Hours grow while powered and stick at the top of the count
    for (int k = 0; k < 2; k++) begin
      hours_preset = k ? 24'hFF_FFFF : 24'h00_0102;
      hours_load = 1'b1;
      @(negedge clk);
      hours_load = 1'b0;
      unit_powered = 1'b1;
      repeat (25) @(negedge clk);
      unit_powered = 1'b0;
      rstr_host_model_i.rd(8'hD6, 8'h00, 4, 0);
      `CHK("hours", k ? 32'h03FF_FFFF : 32'h0304_0100, rstr_host_model_i.got[31:0])
    end
    // Both flags stand high here, so the mid-run reset must visibly clear them
    `CHK("share", 1'b1, share_fault_reg)
    `CHK("warn", 1'b1, overtemp_early_warning_reg)
    rst = 1'b1;
    @(negedge clk);
    `CHK("reset", 3'b000, {rd_valid_reg, share_fault_reg, cmd_known_reg})
    `CHK("reset warn", 1'b0, overtemp_early_warning_reg)
    rst = 1'b0;
    share_current_ma = 16'h2710;
    temp_degc = 8'h59;
    repeat (3) @(negedge clk);
    `CHK("share", 1'b0, share_fault_reg)
    `CHK("warn", 1'b0, overtemp_early_warning_reg)
    rstr_host_model_i.rd(8'hD2, 8'h00, 3, 0);
    `CHK("alarm", 24'hA9_AA00, rstr_host_model_i.got[23:0])
    final_report;
  end
endmodule
